/* verilog/fault_pkg.sv */
// Constants, types and helpers for the analog module fault-status block.
// Assumes one 10 MHz bus clock and an AHB-Lite master on the bus side.
package fault_pkg;

  // ********************************
  // Sizes and timing
  // ********************************
  localparam int NCH       = 4;
  localparam int ADDR_W    = 8;
  localparam int CLK_NS    = 100;
  localparam int TEST_NS   = 5000;
  // Least time, so round up
  localparam int TEST_CYC  = (TEST_NS + CLK_NS - 1) / CLK_NS;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0] OFF_CFG      = 8'h00;
  localparam logic [7:0] OFF_FAULT    = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [3:0] PAGE_DAC     = 4'h1;
  localparam logic [3:0] PAGE_ADC     = 4'h2;
  localparam int         UND_BIT      = 16;
  localparam int         OVR_BIT      = 17;
  localparam logic       RESP_OKAY    = 1'b0;

  // ********************************
  // Fault word
  // ********************************
  typedef enum logic [2:0] {
    CLS_NONE = 3'b000,
    CLS_HW   = 3'b001,
    CLS_CFG  = 3'b010
  } cls_type;

  typedef struct packed {
    logic [3:0] unused;
    cls_type    cls;
    logic [8:0] ext;
  } fault_word_type;

  localparam logic [8:0] EXT_GENERAL  = 9'h000;
  localparam logic [8:0] EXT_POWERUP  = 9'h001;
  localparam logic [8:0] EXT_RANGE_B  = 9'h001;
  localparam logic [8:0] EXT_FILTER_B = 9'h005;
  localparam logic [8:0] EXT_FORMAT_B = 9'h009;

  // ********************************
  // Channel configuration
  // ********************************
  typedef struct packed {
    logic [1:0] format;
    logic [1:0] filter;
    logic [1:0] range;
  } ch_cfg_type;

  typedef ch_cfg_type [NCH-1:0] cfg_type;
  typedef logic [NCH-1:0][15:0] chan_bus_type;
  localparam logic [1:0] SEL_BAD = 2'b11;

  // Limits per range code; code 3 is never accepted
  localparam logic [3:0][15:0] RANGE_HI =
    {16'hffff, 16'h6000, 16'h7d00, 16'h7fff};
  localparam logic [3:0][15:0] RANGE_LO =
    {16'h0000, 16'h0800, 16'h0400, 16'h0000};

  // Interrupt status bits
  localparam int IRQ_W     = 4;
  localparam int IRQ_HW    = 0;
  localparam int IRQ_CFG   = 1;
  localparam int IRQ_RANGE = 2;
  localparam int IRQ_READY = 3;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_LOAD  = 3'b001,
    ST_CHECK = 3'b010,
    ST_RUN   = 3'b011,
    ST_FAIL  = 3'b100
  } st_type;

  // Returns {bad, code}; lowest code wins when several options are bad
  function automatic logic [9:0] cfg_check(input cfg_type c);
    logic [9:0] res;
    res = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (c[i].format == SEL_BAD) res = {1'b1, EXT_FORMAT_B + 9'(i)};
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (c[i].filter == SEL_BAD) res = {1'b1, EXT_FILTER_B + 9'(i)};
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (c[i].range == SEL_BAD) res = {1'b1, EXT_RANGE_B + 9'(i)};
    end
    return res;
  endfunction

endpackage

/* verilog/pin_sync.sv */
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes a multi-bit bus is held stable by its source for several clocks.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } sync_type;

  sync_type r_reg;
  sync_type r_next;

  // First stage feeds only the second stage
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule

/* verilog/analog_fault_status.sv */
// Fault-status block of an analog I/O module with an AHB-Lite slave.
// Assumes the sole slave on its bus: hreadyout is the bus hready.
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module analog_fault_status (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    ce,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire fault_pkg::chan_bus_type adc_in,
  input  wire logic                    hw_fault_in,
  output fault_pkg::chan_bus_type      dac_out,
  output fault_pkg::fault_word_type    fault_word,
  output logic                         critical_err,
  output logic                         module_ok,
  output logic                         irq
);
  import fault_pkg::*;

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    st_type         st;
    logic [7:0]     cnt;
    cfg_type        cfg;
    logic           cfg_err;
    logic [8:0]     cfg_code;
    fault_word_type fw;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic           irq_q;
    logic           hw_seen;
    chan_bus_type   dac;
    chan_bus_type   dac_q;
    chan_bus_type   adc;
    logic [NCH-1:0] ovr;
    logic [NCH-1:0] und;
    logic           a_valid;
    logic           a_write;
    logic [ADDR_W-1:0] a_addr;
    logic [31:0]    rdata;
  } state_type;

  localparam state_type RESET_STATE = '0;
  localparam int SYNC_W = NCH * 16 + 1;

  state_type r_reg;
  state_type r_next;

  logic [SYNC_W-1:0] sync_q;
  chan_bus_type      adc_s;
  logic              hw_s;

  // ********************************
  // Pin synchronisers
  // ********************************
  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       ({hw_fault_in, adc_in}),
    .q       (sync_q)
  );

  assign adc_s = sync_q[SYNC_W-2:0];
  assign hw_s  = sync_q[SYNC_W-1];

  // ********************************
  // Next-state logic
  // ********************************
  always_comb begin
    logic [9:0]        chk;
    logic [IRQ_W-1:0]  ev;
    logic              rd_clear;
    logic [31:0]       rd;
    logic [ADDR_W-1:0] ra;
    logic [ADDR_W-1:0] wa;
    logic              fault;
    chk      = '0;
    ev       = '0;
    rd_clear = 1'b0;
    rd       = '0;
    ra       = haddr[ADDR_W-1:0];
    wa       = r_reg.a_addr;
    fault    = 1'b0;
    r_next   = r_reg;

    // Data phase of a write: registers take hwdata now
    if (r_reg.a_valid && r_reg.a_write) begin
      if (wa == OFF_CFG) begin
        chk = cfg_check(hwdata[$bits(cfg_type)-1:0]);
        if (chk[9]) begin
          // Bad settings are dropped; the old ones stay active
          r_next.cfg_err  = 1'b1;
          r_next.cfg_code = chk[8:0];
          ev[IRQ_CFG]     = 1'b1;
        end else begin
          r_next.cfg     = hwdata[$bits(cfg_type)-1:0];
          r_next.cfg_err = 1'b0;
        end
      end else if (wa == OFF_IRQ_MASK) begin
        r_next.irq_mask = hwdata[IRQ_W-1:0];
      end else if (wa[7:4] == PAGE_DAC) begin
        r_next.dac[wa[3:2]] = hwdata[15:0];
      end
    end

    // Address phase: latch it, and build read data for the data phase
    r_next.a_valid = hsel && hready && htrans[1];
    r_next.a_write = hwrite;
    r_next.a_addr  = ra;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (ra == OFF_CFG) begin
        rd[$bits(cfg_type)-1:0] = r_reg.cfg;
      end else if (ra == OFF_FAULT) begin
        rd[15:0] = r_reg.fw;
      end else if (ra == OFF_IRQ_STAT) begin
        rd[IRQ_W-1:0] = r_reg.irq_stat;
        rd_clear      = 1'b1;
      end else if (ra == OFF_IRQ_MASK) begin
        rd[IRQ_W-1:0] = r_reg.irq_mask;
      end else if (ra[7:4] == PAGE_DAC) begin
        rd[15:0] = r_reg.dac[ra[3:2]];
      end else if (ra[7:4] == PAGE_ADC) begin
        // Range flags live beside the sample, not in the fault word
        rd[15:0]    = r_reg.adc[ra[3:2]];
        rd[UND_BIT] = r_reg.und[ra[3:2]];
        rd[OVR_BIT] = r_reg.ovr[ra[3:2]];
      end
      r_next.rdata = rd;
    end

    // Power-up self test before normal operation
    unique case (r_reg.st)
      ST_RESET: begin
        r_next.cnt = '0;
        r_next.st  = ST_LOAD;
      end
      ST_LOAD: begin
        chk = cfg_check(r_reg.cfg);
        if (chk[9]) begin
          r_next.st = ST_FAIL;
        end else begin
          r_next.st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (hw_s) begin
          r_next.st = ST_FAIL;
        end else if (r_reg.cnt == 8'(TEST_CYC - 1)) begin
          r_next.st      = ST_RUN;
          ev[IRQ_READY]  = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + 8'd1;
        end
      end
      ST_RUN: begin
        r_next.st = ST_RUN;
      end
      ST_FAIL: begin
        // Only a reset leaves a failed self test
        r_next.st = ST_FAIL;
      end
      default: begin
        r_next.st = ST_FAIL;
      end
    endcase

    // Fault word: hardware outranks configuration
    r_next.fw.unused = '0;
    if (r_next.st == ST_FAIL) begin
      r_next.fw.cls = CLS_HW;
      r_next.fw.ext = EXT_GENERAL;
    end else if (r_next.st != ST_RUN) begin
      r_next.fw.cls = CLS_HW;
      r_next.fw.ext = EXT_POWERUP;
    end else if (hw_s) begin
      r_next.fw.cls = CLS_HW;
      r_next.fw.ext = EXT_GENERAL;
    end else if (r_next.cfg_err) begin
      r_next.fw.cls = CLS_CFG;
      r_next.fw.ext = r_next.cfg_code;
    end else begin
      r_next.fw.cls = CLS_NONE;
      r_next.fw.ext = '0;
    end
    fault = (r_next.fw.cls != CLS_NONE);

    // Outputs go to zero while any fault stands
    for (int i = 0; i < NCH; i++) begin
      r_next.dac_q[i] = fault ? '0 : r_next.dac[i];
    end

    // Input table and range flags, updated only in normal running
    if (r_reg.st == ST_RUN) begin
      for (int i = 0; i < NCH; i++) begin
        r_next.adc[i] = adc_s[i];
        r_next.ovr[i] = adc_s[i] > RANGE_HI[r_reg.cfg[i].range];
        r_next.und[i] = adc_s[i] < RANGE_LO[r_reg.cfg[i].range];
      end
    end
    ev[IRQ_RANGE] = |((r_next.ovr | r_next.und) & ~(r_reg.ovr | r_reg.und));

    // A new hardware fault is an event once per rising edge
    r_next.hw_seen = hw_s || (r_next.st == ST_FAIL);
    ev[IRQ_HW]     = r_next.hw_seen && !r_reg.hw_seen;

    // Sticky status: a set in the reading cycle survives the clear
    r_next.irq_stat = (r_reg.irq_stat & ~{IRQ_W{rd_clear}}) | ev;
    r_next.irq_q    = |(r_next.irq_stat & r_next.irq_mask);
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= RESET_STATE;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // Frozen state cannot take a transfer, so stall the bus while ce is low
  assign hreadyout    = ce;
  assign hresp        = RESP_OKAY;
  assign hrdata       = r_reg.rdata;
  assign dac_out      = r_reg.dac_q;
  assign fault_word   = r_reg.fw;
  // Host leaves run mode on this level
  assign critical_err = (r_reg.fw.cls == CLS_HW);
  assign module_ok    = (r_reg.st == ST_RUN) && !critical_err;
  assign irq          = r_reg.irq_q;

endmodule

/* tb/fault_chk.sv */
// Assertion checker for the analog fault-status block.
// Assumes one clock, hclk, and the async active-low reset hresetn.
`timescale 1ns/1ps
module fault_chk
  import fault_pkg::*;
(
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      ce,
  input wire logic                      hsel,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic                      hw_fault_in,
  input wire fault_pkg::chan_bus_type   dac_out,
  input wire fault_pkg::fault_word_type fault_word,
  input wire logic                      critical_err,
  input wire logic                      module_ok
);
  // ****************************************
  // Properties on the fault word
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus write taken at this edge
  logic wr;
  assign wr = hsel && hready && htrans[1] && hwrite && ce;

  property p_zero; fault_word.cls != CLS_NONE |-> dac_out == '0; endproperty
  a_zero: assert property (p_zero)
    else $error("outputs not zero during a fault");
  property p_top; fault_word.unused == 4'h0; endproperty
  a_top: assert property (p_top)
    else $error("top nibble of fault word not zero");
  property p_cls; fault_word.cls inside {CLS_NONE, CLS_HW, CLS_CFG};
  endproperty
  a_cls: assert property (p_cls)
    else $error("undefined fault class");
  property p_none; fault_word.cls == CLS_NONE |-> fault_word.ext == 9'h0;
  endproperty
  a_none: assert property (p_none)
    else $error("detail bits set with no error");
  property p_crit; critical_err == (fault_word.cls == CLS_HW); endproperty
  a_crit: assert property (p_crit)
    else $error("critical flag differs from class");
  property p_pwr; $rose(hresetn) && ce |=> fault_word == 16'h0201;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("no power-up code after reset");
  property p_hwpin;
    ce && module_ok && hw_fault_in |-> ##[1:4] fault_word.cls == CLS_HW;
  endproperty
  a_hwpin: assert property (p_hwpin)
    else $error("hardware fault not reported");
  property p_hold;
    fault_word.cls == CLS_CFG && !hw_fault_in && !$past(hw_fault_in)
      && !$past(hw_fault_in, 2) && !$past(wr) |=> $stable(fault_word);
  endproperty
  a_hold: assert property (p_hold)
    else $error("fault code changed without cause");
  property p_run; fault_word.cls == CLS_CFG |-> module_ok && !critical_err;
  endproperty
  a_run: assert property (p_run)
    else $error("config fault stopped the module");

  // Main scenarios reached
  c_cfg: cover property (fault_word.cls == CLS_CFG);
  c_ok: cover property ($rose(module_ok));
  c_hw: cover property (module_ok ##1 critical_err);
endmodule

bind analog_fault_status fault_chk fault_chk_i (
  .hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready, .hw_fault_in,
  .dac_out, .fault_word, .critical_err, .module_ok
);

/* tb/host_model.sv */
// Model of the host controller's run mode as it watches the module.
// Assumes the module's status levels are synchronous to hclk.
`timescale 1ns/1ps
module host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic module_ok,
  input wire logic critical_err,
  output logic     run_mode
);
  // Enter run once the module is ready; a critical error wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_mode <= 1'b0;
    else if (critical_err) run_mode <= 1'b0;
    else if (module_ok) run_mode <= 1'b1;
  end
endmodule

/* tb/analog_fault_status_test.sv */
// Testbench for the analog fault-status block over AHB-Lite.
// Assumes the block is the only slave, so hready is its hreadyout.
`timescale 1ns/1ps
module analog_fault_status_test;
  import fault_pkg::*;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic           hclk = 0, hresetn = 0, ce = 1, hsel = 1, hwrite = 0;
  logic           hw_fault_in = 0;
  logic [31:0]    haddr = 0, hwdata = 0, hrdata;
  logic [1:0]     htrans = 0;
  logic [2:0]     hsize = 3'h2;
  logic           hready, hreadyout, hresp, critical_err, module_ok;
  logic           irq, run_mode;
  chan_bus_type   adc_in = '0, dac_out;
  fault_word_type fault_word;
  int             err_total = 0, checks_done = 0, cycles = 0;

  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  analog_fault_status analog_fault_status_i (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .adc_in, .hw_fault_in,
    .dac_out, .fault_word, .critical_err, .module_ok, .irq
  );
  host_model host_model_i (
    .hclk, .hresetn, .module_ok, .critical_err, .run_mode
  );

  // ****************************************
  // Tasks
  // ****************************************
  task end_of_test;
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One single transfer; waits on hready, never on a fixed count
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(hrdata, e);
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(fault_word, 32'h0201);
    xfer(OFF_CFG, 1'b1, 32'h0);
    xfer(8'h10, 1'b1, 32'h1234);
    @(posedge hclk);
    chk(dac_out[0], 32'h0);
    for (int n = 0; n < 200 && module_ok !== 1'b1; n++) @(posedge hclk);
    @(posedge hclk);
    chk(fault_word, 32'h0);
    chk(dac_out[0], 32'h1234);
    chk(run_mode, 32'h1);
    rchk(OFF_IRQ_STAT, 32'h8);
    rchk(OFF_IRQ_STAT, 32'h0);
    xfer(OFF_IRQ_MASK, 1'b1, 32'h2);
    // Every bad option field on every channel; code must hold
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < NCH; i++) begin
        xfer(OFF_CFG, 1'b1, 32'h3 << (6 * i + 2 * k));
        repeat (20) @(posedge hclk);
        chk(fault_word, {7'h02, 9'(1 + 4 * k + i)});
        chk(dac_out[0], 32'h0);
        chk({module_ok, irq, critical_err}, 32'h6);
      end
    end
    rchk(OFF_CFG, 32'h0);
    rchk(OFF_IRQ_STAT, 32'h2);
    @(posedge hclk);
    chk(irq, 32'h0);
    xfer(OFF_CFG, 1'b1, 32'h0);
    @(posedge hclk);
    chk(fault_word, 32'h0);
    chk(dac_out[0], 32'h1234);
    adc_in[0] <= RANGE_HI[0] + 16'h1;
    repeat (6) @(posedge hclk);
    rchk(8'h20, {14'h0, 2'b10, RANGE_HI[0] + 16'h1});
    chk(fault_word, 32'h0);
    hw_fault_in <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(fault_word, 32'h0200);
    chk(dac_out[0], 32'h0);
    chk(run_mode, 32'h0);
    hw_fault_in <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(fault_word, 32'h0);
    xfer(8'hfc, 1'b1, 32'hffff);
    rchk(8'hfc, 32'h0);
    rchk(OFF_IRQ_STAT, 32'h5);
    chk({hreadyout, hresp}, 32'h2);
    // Frozen block must not see the fault pin until ce returns
    ce <= 1'b0;
    hw_fault_in <= 1'b1;
    repeat (6) @(posedge hclk);
    chk({fault_word, hreadyout}, 32'h0);
    ce <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(fault_word, 32'h0200);
    // Second reset with the pin high: self test fails for good
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (80) @(posedge hclk);
    xfer(8'h10, 1'b1, 32'h1234);
    @(posedge hclk);
    chk({fault_word, critical_err, module_ok}, {16'h0200, 2'b10});
    chk(dac_out[0], 32'h0);
    rchk(OFF_IRQ_STAT, 32'h1);
    hw_fault_in <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(fault_word, 32'h0200);
    end_of_test();
  end
endmodule
